// ---- design/tpg_top.sv ----
// Notes on behaviour
// - polarity 0 means rising stimulus edge asserts, 1 means falling edge asserts.
// - train mode starts an endless pulse train on first assertion edge.
// - single mode emits one pulse on the first edge, ignores later edges.
// - rearmed mode emits one whole pulse per assertion edge; edges during a pulse are held as at most one more pulse.
// - mode 3 halts the addressed generator, output back to inactive level.
// - stop names the generator by its handle; each configuration gets a fresh one.
// - after start, first phase lasts the programmed delay.
// - second phase lasts the programmed width, then pulse ends or train repeats.
// - second phase at pulse polarity, first phase at opposite level.
// - encoder units: delay or width of 0 still lasts one count.
// - output type 0 external, 1 sync bus, 3 isolated out; number picks line.
// - stimulus type 0 external, 1 sync bus, 2 isolated in, 4 status event.
// - status 15 asserts at acquisition start, 8 at acquisition finish.
// - status 18 asserts at camera line sync.
// - status 19 asserts at frame sync; refused during line scan.
// - status 9 asserts at frame start, 10 at frame end.
// - status 16 counts as asserted at once.
// - stimulus line number selects the line within the chosen type.
// - fixed generator count shared with camera control; overflow reports exhaustion.
`timescale 1ns/1ps
`default_nettype none

module tpg_top #(
	parameter int NUM_GEN   = 2,
	parameter int NUM_LINES = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 cfg_valid_i,
	input  wire tpg_pkg::tpg_cfg_t    cfg_i,
	input  wire logic                 line_scan_i,
	input  wire logic [NUM_GEN-1:0]   cam_reserved_i,
	input  wire logic                 enc_tick_i,
	input  wire tpg_pkg::tpg_status_t status_i,
	input  wire logic [NUM_LINES-1:0] ext_in_i,
	input  wire logic [NUM_LINES-1:0] sync_in_i,
	input  wire logic [NUM_LINES-1:0] iso_in_i,
	output tpg_pkg::tpg_resp_t        resp_o,
	output logic [NUM_GEN-1:0]        busy_o,
	output logic [NUM_LINES-1:0]      ext_out_o,
	output logic [NUM_LINES-1:0]      ext_oe_o,
	output logic [NUM_LINES-1:0]      sync_out_o,
	output logic [NUM_LINES-1:0]      sync_oe_o,
	output logic [NUM_LINES-1:0]      iso_out_o
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (!(NUM_GEN == 2 || NUM_GEN == 3 || NUM_GEN == 6)) begin : g_bad_gen
		$error("generator count must be 2, 3 or 6");
	end
	if (NUM_LINES < 1 || NUM_LINES > (1 << tpg_pkg::NUM_W)) begin : g_bad_lines
		$error("line count out of range");
	end

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	logic [NUM_GEN-1:0]           busy_q;
	logic [tpg_pkg::HANDLE_W-1:0] hdl_q [NUM_GEN];
	logic [tpg_pkg::HANDLE_W-1:0] next_hdl_q;
	tpg_pkg::tpg_resp_t           resp_q;
	logic [NUM_GEN-1:0]           free;
	logic [NUM_GEN-1:0]           hit;
	logic [NUM_GEN-1:0]           pick;
	logic [NUM_GEN-1:0]           load;
	logic [NUM_GEN-1:0]           stop;

	wire is_stop  = cfg_i.mode == tpg_pkg::MODE_STOP;
	wire stim_ok  = cfg_i.stim_type == tpg_pkg::LINE_EXT
		|| cfg_i.stim_type == tpg_pkg::LINE_SYNC
		|| cfg_i.stim_type == tpg_pkg::LINE_ISO_IN
		|| cfg_i.stim_type == tpg_pkg::LINE_STATUS;
	wire ev_known = cfg_i.status_ev == tpg_pkg::EV_ACQ_RUN
		|| cfg_i.status_ev == tpg_pkg::EV_ACQ_DONE
		|| cfg_i.status_ev == tpg_pkg::EV_HSYNC
		|| cfg_i.status_ev == tpg_pkg::EV_VSYNC
		|| cfg_i.status_ev == tpg_pkg::EV_FRAME_START
		|| cfg_i.status_ev == tpg_pkg::EV_FRAME_DONE
		|| cfg_i.status_ev == tpg_pkg::EV_IMMEDIATE;
	// frame sync has no meaning for a line scan camera
	wire vs_bad   = cfg_i.status_ev == tpg_pkg::EV_VSYNC && line_scan_i;
	wire ev_ok    = cfg_i.stim_type != tpg_pkg::LINE_STATUS || (ev_known && !vs_bad);
	wire dst_ok   = cfg_i.dst_type == tpg_pkg::LINE_EXT
		|| cfg_i.dst_type == tpg_pkg::LINE_SYNC
		|| cfg_i.dst_type == tpg_pkg::LINE_ISO_OUT;
	wire num_ok   = 32'(cfg_i.stim_num) < NUM_LINES && 32'(cfg_i.dst_num) < NUM_LINES;
	wire param_ok = stim_ok && ev_ok && dst_ok && num_ok;
	wire cfg_req  = cfg_valid_i && !is_stop && param_ok;
	wire stop_req = cfg_valid_i && is_stop;
	wire any_free = |free;
	wire any_hit  = |hit;

	// lowest free generator wins
	always_comb begin
		pick = '0;
		for (int g = NUM_GEN - 1; g >= 0; g--) begin
			free[g] = !busy_q[g] && !cam_reserved_i[g];
			hit[g]  = busy_q[g] && hdl_q[g] == cfg_i.handle;
			if (free[g]) begin
				pick = '0;
				pick[g] = 1'b1;
			end
		end
	end

	assign load = cfg_req ? pick : '0;
	assign stop = stop_req ? hit : '0;

	// ----------------------------------------
	// answer to software
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_q     <= '0;
			next_hdl_q <= tpg_pkg::HANDLE_RST;
		end else begin
			resp_q.ack         <= cfg_valid_i;
			resp_q.err_exhaust <= cfg_req && !any_free;
			resp_q.err_param   <= cfg_valid_i && !is_stop && !param_ok;
			resp_q.err_handle  <= stop_req && !any_hit;
			// handle holds between requests so software can read it late
			if (cfg_valid_i) begin
				resp_q.handle <= stop_req ? cfg_i.handle : next_hdl_q;
			end
			if (cfg_req && any_free) begin
				next_hdl_q <= next_hdl_q + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// generators
	// ----------------------------------------
	logic [NUM_GEN-1:0]       lvl_q;
	logic [NUM_GEN-1:0]       drv_q;
	logic [2:0]               dty [NUM_GEN];
	logic [tpg_pkg::NUM_W-1:0] dnum [NUM_GEN];

	for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
		tpg_pkg::tpg_cfg_t    cfg_q;
		tpg_pkg::tpg_state_t  st_q;
		logic [tpg_pkg::CNT_W-1:0] cnt_q;
		logic                 prev_q;
		logic                 skip_q;
		logic                 pend_q;
		logic                 ev_lvl;

		always_comb begin
			case (cfg_q.status_ev)
				tpg_pkg::EV_ACQ_RUN:     ev_lvl = status_i.acq_run;
				tpg_pkg::EV_ACQ_DONE:    ev_lvl = status_i.acq_done;
				tpg_pkg::EV_HSYNC:       ev_lvl = status_i.hsync;
				tpg_pkg::EV_VSYNC:       ev_lvl = status_i.vsync;
				tpg_pkg::EV_FRAME_START: ev_lvl = status_i.frame_start;
				tpg_pkg::EV_FRAME_DONE:  ev_lvl = status_i.frame_done;
				default:                 ev_lvl = 1'b0;
			endcase
		end

		// line selection by type then number
		wire stim_lvl =
			cfg_q.stim_type == tpg_pkg::LINE_EXT  ? ext_in_i[cfg_q.stim_num] :
			cfg_q.stim_type == tpg_pkg::LINE_SYNC ? sync_in_i[cfg_q.stim_num] :
			cfg_q.stim_type == tpg_pkg::LINE_ISO_IN ? iso_in_i[cfg_q.stim_num] :
			ev_lvl;
		wire immed  = cfg_q.stim_type == tpg_pkg::LINE_STATUS
			&& cfg_q.status_ev == tpg_pkg::EV_IMMEDIATE;
		wire rise   = stim_lvl && !prev_q;
		wire fall   = !stim_lvl && prev_q;
		wire edge_s = immed
			|| (!skip_q && (cfg_q.stim_pol == tpg_pkg::EDGE_RISE ? rise : fall));
		wire tick   = cfg_q.units == tpg_pkg::UNIT_TIME || enc_tick_i;
		wire last   = tick && cnt_q <= tpg_pkg::CNT_ONE;
		// a zero length still takes one tick
		wire [tpg_pkg::CNT_W-1:0] dly_len =
			cfg_q.delay == '0 ? tpg_pkg::CNT_ONE : cfg_q.delay;
		wire [tpg_pkg::CNT_W-1:0] wid_len =
			cfg_q.width == '0 ? tpg_pkg::CNT_ONE : cfg_q.width;
		wire in_pulse = st_q == tpg_pkg::ST_DELAY || st_q == tpg_pkg::ST_WIDTH;
		wire rearm    = cfg_q.mode == tpg_pkg::MODE_REARM;
		// an edge during a pulse is held, the consume beats a set in the same cycle
		wire more     = pend_q || (rearm && edge_s);
		wire w_end    = st_q == tpg_pkg::ST_WIDTH && last;

		assign dty[g]  = cfg_q.dst_type;
		assign dnum[g] = cfg_q.dst_num;

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cfg_q     <= '0;
				st_q      <= tpg_pkg::ST_IDLE;
				cnt_q     <= '0;
				prev_q    <= 1'b0;
				skip_q    <= 1'b0;
				pend_q    <= 1'b0;
				busy_q[g] <= 1'b0;
				hdl_q[g]  <= tpg_pkg::HANDLE_RST;
				lvl_q[g]  <= 1'b0;
				drv_q[g]  <= 1'b0;
			end else begin
				prev_q <= stim_lvl;
				skip_q <= load[g];
				pend_q <= rearm && in_pulse && !w_end && more;
				if (load[g]) begin
					cfg_q     <= cfg_i;
					st_q      <= tpg_pkg::ST_ARMED;
					busy_q[g] <= 1'b1;
					hdl_q[g]  <= next_hdl_q;
					lvl_q[g]  <= !cfg_i.pulse_pol;
					drv_q[g]  <= 1'b1;
				end else if (stop[g]) begin
					st_q      <= tpg_pkg::ST_IDLE;
					busy_q[g] <= 1'b0;
					lvl_q[g]  <= !cfg_q.pulse_pol;
				end else begin
					case (st_q)
						tpg_pkg::ST_ARMED: begin
							if (edge_s) begin
								st_q  <= tpg_pkg::ST_DELAY;
								cnt_q <= dly_len;
							end
						end
						tpg_pkg::ST_DELAY: begin
							if (last) begin
								st_q     <= tpg_pkg::ST_WIDTH;
								cnt_q    <= wid_len;
								lvl_q[g] <= cfg_q.pulse_pol;
							end else if (tick) begin
								cnt_q <= cnt_q - tpg_pkg::CNT_ONE;
							end
						end
						tpg_pkg::ST_WIDTH: begin
							if (last) begin
								lvl_q[g] <= !cfg_q.pulse_pol;
								cnt_q    <= dly_len;
								case (cfg_q.mode)
									tpg_pkg::MODE_TRAIN: st_q <= tpg_pkg::ST_DELAY;
									tpg_pkg::MODE_REARM:
										st_q <= more ? tpg_pkg::ST_DELAY : tpg_pkg::ST_ARMED;
									default: begin
										st_q      <= tpg_pkg::ST_IDLE;
										busy_q[g] <= 1'b0;
									end
								endcase
							end else if (tick) begin
								cnt_q <= cnt_q - tpg_pkg::CNT_ONE;
							end
						end
						default: st_q <= tpg_pkg::ST_IDLE;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// output line drive
	// ----------------------------------------
	logic [NUM_LINES-1:0] ext_d;
	logic [NUM_LINES-1:0] ext_oe_d;
	logic [NUM_LINES-1:0] sync_d;
	logic [NUM_LINES-1:0] sync_oe_d;
	logic [NUM_LINES-1:0] iso_d;
	logic [NUM_LINES-1:0] ext_q;
	logic [NUM_LINES-1:0] ext_oe_q;
	logic [NUM_LINES-1:0] sync_q;
	logic [NUM_LINES-1:0] sync_oe_q;
	logic [NUM_LINES-1:0] iso_q;

	// two generators on one line simply OR together
	always_comb begin
		ext_d     = '0;
		ext_oe_d  = '0;
		sync_d    = '0;
		sync_oe_d = '0;
		iso_d     = '0;
		for (int g = 0; g < NUM_GEN; g++) begin
			for (int l = 0; l < NUM_LINES; l++) begin
				if (drv_q[g] && 32'(dnum[g]) == l) begin
					if (dty[g] == tpg_pkg::LINE_EXT) begin
						ext_d[l]    = ext_d[l] | lvl_q[g];
						ext_oe_d[l] = 1'b1;
					end
					if (dty[g] == tpg_pkg::LINE_SYNC) begin
						sync_d[l]    = sync_d[l] | lvl_q[g];
						sync_oe_d[l] = 1'b1;
					end
					if (dty[g] == tpg_pkg::LINE_ISO_OUT) begin
						iso_d[l] = iso_d[l] | lvl_q[g];
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_q     <= '0;
			ext_oe_q  <= '0;
			sync_q    <= '0;
			sync_oe_q <= '0;
			iso_q     <= '0;
		end else begin
			ext_q     <= ext_d;
			ext_oe_q  <= ext_oe_d;
			sync_q    <= sync_d;
			sync_oe_q <= sync_oe_d;
			iso_q     <= iso_d;
		end
	end

	assign resp_o     = resp_q;
	assign busy_o     = busy_q;
	assign ext_out_o  = ext_q;
	assign ext_oe_o   = ext_oe_q;
	assign sync_out_o = sync_q;
	assign sync_oe_o  = sync_oe_q;
	assign iso_out_o  = iso_q;

endmodule

`default_nettype wire

// ---- include/tpg_pkg.sv ----
package tpg_pkg;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int              CNT_W      = 32;
	localparam int              NUM_W      = 3;
	localparam int              HANDLE_W   = 8;
	localparam logic [7:0]      HANDLE_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE   = 32'h0000_0001;

	// ----------------------------------------
	// trigger line types
	// ----------------------------------------
	localparam logic [2:0] LINE_EXT     = 3'h0;
	localparam logic [2:0] LINE_SYNC    = 3'h1;
	localparam logic [2:0] LINE_ISO_IN  = 3'h2;
	localparam logic [2:0] LINE_ISO_OUT = 3'h3;
	localparam logic [2:0] LINE_STATUS  = 3'h4;

	// ----------------------------------------
	// status event codes
	// ----------------------------------------
	localparam logic [4:0] EV_ACQ_DONE    = 5'h08;
	localparam logic [4:0] EV_FRAME_START = 5'h09;
	localparam logic [4:0] EV_FRAME_DONE  = 5'h0a;
	localparam logic [4:0] EV_ACQ_RUN     = 5'h0f;
	localparam logic [4:0] EV_IMMEDIATE   = 5'h10;
	localparam logic [4:0] EV_HSYNC       = 5'h12;
	localparam logic [4:0] EV_VSYNC       = 5'h13;

	// ----------------------------------------
	// polarity and units
	// ----------------------------------------
	localparam logic EDGE_RISE  = 1'b0;
	localparam logic UNIT_TIME  = 1'b0;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_TRAIN  = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_REARM  = 2'b10,
		MODE_STOP   = 2'b11
	} tpg_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_DELAY = 2'b10,
		ST_WIDTH = 2'b11
	} tpg_state_t;

	typedef struct packed {
		tpg_mode_t           mode;
		logic                stim_pol;
		logic [2:0]          stim_type;
		logic [NUM_W-1:0]    stim_num;
		logic [4:0]          status_ev;
		logic [2:0]          dst_type;
		logic [NUM_W-1:0]    dst_num;
		logic                pulse_pol;
		logic                units;
		logic [CNT_W-1:0]    delay;
		logic [CNT_W-1:0]    width;
		logic [HANDLE_W-1:0] handle;
	} tpg_cfg_t;

	typedef struct packed {
		logic acq_run;
		logic acq_done;
		logic hsync;
		logic vsync;
		logic frame_start;
		logic frame_done;
	} tpg_status_t;

	typedef struct packed {
		logic                ack;
		logic                err_exhaust;
		logic                err_param;
		logic                err_handle;
		logic [HANDLE_W-1:0] handle;
	} tpg_resp_t;

endpackage

// ---- tb/tb_tpg_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end

module tb_tpg_top;
	logic                 clk_i = 0, rst_i = 1, cfg_valid_i = 0, line_scan_i = 0, enc_tick_i = 0, fire = 0;
	logic [1:0]           cam_reserved_i = '0, tk = '0, dsel = '0;
	logic [2:0]           f_typ = '0, f_num = '0;
	logic [7:0]           ext_in_i, sync_in_i, iso_in_i, ext_out_o, ext_oe_o, sync_out_o, sync_oe_o, iso_out_o, h;
	logic [1:0]           busy_o;
	tpg_pkg::tpg_cfg_t    cfg_i = '0;
	tpg_pkg::tpg_status_t status_i;
	tpg_pkg::tpg_resp_t   resp_o;
	int                   n_errors = 0, n_compared = 0, d, w;
	wire                  mon = dsel == 2'h0 ? ext_out_o[0] : dsel == 2'h1 ? sync_out_o[0] : iso_out_o[0];

	tpg_top dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_valid_i(cfg_valid_i), .cfg_i(cfg_i), .line_scan_i(line_scan_i),
		.cam_reserved_i(cam_reserved_i), .enc_tick_i(enc_tick_i), .status_i(status_i), .ext_in_i(ext_in_i),
		.sync_in_i(sync_in_i), .iso_in_i(iso_in_i), .resp_o(resp_o), .busy_o(busy_o), .ext_out_o(ext_out_o),
		.ext_oe_o(ext_oe_o), .sync_out_o(sync_out_o), .sync_oe_o(sync_oe_o), .iso_out_o(iso_out_o));
	tpg_line_model u_line (.clk_i(clk_i), .fire_i(fire), .typ_i(f_typ), .num_i(f_num), .ext_out_i(ext_out_o),
		.ext_oe_i(ext_oe_o), .sync_out_i(sync_out_o), .sync_oe_i(sync_oe_o), .ext_in_o(ext_in_i),
		.sync_in_o(sync_in_i), .iso_in_o(iso_in_i), .status_o(status_i));

	initial forever #2 clk_i = ~clk_i;
	// encoder count every fourth clock
	always @(posedge clk_i) begin
		tk <= tk + 2'h1;
		enc_tick_i <= tk == 2'h3;
	end

	// ----
	// helpers
	// ----
	// delay and width kept above zero in time units, whole counts in encoder units
	function automatic tpg_pkg::tpg_cfg_t mk(input logic [1:0] m, input logic sp, input logic [2:0] st,
			input logic [2:0] sn, input logic [4:0] ev, input logic [2:0] dt, input logic pp, input logic u,
			input logic [31:0] dl, input logic [31:0] wd);
		mk = '{tpg_pkg::tpg_mode_t'(m), sp, st, sn, ev, dt, 3'h0, pp, u, dl, wd, 8'h00};
	endfunction
	task automatic req(input tpg_pkg::tpg_cfg_t c);
		@(posedge clk_i) begin cfg_i <= c; cfg_valid_i <= 1'b1; end
		@(posedge clk_i) cfg_valid_i <= 1'b0;
		#1;
	endtask
	task automatic stop(input logic [7:0] hh, input logic e);
		tpg_pkg::tpg_cfg_t c;
		c = '0;
		c.mode = tpg_pkg::MODE_STOP;
		c.handle = hh;
		req(c);
		`CHK(resp_o.err_handle, e, "stop handle")
	endtask
	task automatic poke(input logic [2:0] t, input logic [2:0] n);
		@(posedge clk_i) begin fire <= 1'b1; f_typ <= t; f_num <= n; end
		@(posedge clk_i) fire <= 1'b0;
	endtask
	// cycles until the watched line goes to p, then cycles it stays there
	task automatic meas(input logic p, input int lim);
		#1;
		d = 0;
		w = 0;
		while (mon !== p && d < lim) begin @(posedge clk_i); #1; d++; end
		while (mon === p && w < lim) begin @(posedge clk_i); #1; w++; end
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_single;
		dsel = 2'h0;
		req(mk(2'h1, 1'b0, 3'h4, 3'h0, tpg_pkg::EV_IMMEDIATE, 3'h0, 1'b1, 1'b0, 32'h2, 32'h3));
		`CHK(resp_o.handle, tpg_pkg::HANDLE_RST, "first handle")
		`CHK(busy_o[0], 1'b1, "allocated")
		meas(1'b1, 50);
		`CHK(d, 4, "delay")
		`CHK(ext_oe_o[0], 1'b1, "line driven")
		`CHK(w, 3, "width")
		`CHK(busy_o[0], 1'b0, "single done")
		meas(1'b1, 20);
		`CHK(w, 0, "no second pulse")
		$display("t_single done");
	endtask
	task automatic t_edge;
		dsel = 2'h1;
		req(mk(2'h2, 1'b1, 3'h0, 3'h2, 5'h00, 3'h1, 1'b0, 1'b0, 32'h3, 32'h2));
		h = resp_o.handle;
		repeat (2) @(posedge clk_i);
		#1 `CHK(mon, 1'b1, "first phase level")
		`CHK(sync_oe_o[0], 1'b1, "sync line driven")
		poke(3'h0, 3'h2);
		meas(1'b0, 12);
		`CHK(w, 0, "rising edge ignored")
		repeat (2) begin
			poke(3'h0, 3'h2);
			meas(1'b0, 30);
			`CHK(w, 2, "rearmed pulse")
			poke(3'h0, 3'h2);
		end
		stop(h, 1'b0);
		`CHK(busy_o, 2'h0, "stopped")
		$display("t_edge done");
	endtask
	task automatic t_train;
		dsel = 2'h2;
		req(mk(2'h0, 1'b0, 3'h4, 3'h0, tpg_pkg::EV_ACQ_RUN, 3'h3, 1'b1, 1'b0, 32'h2, 32'h3));
		h = resp_o.handle;
		poke(3'h4, 3'h5);
		meas(1'b1, 30);
		`CHK(w, 3, "train first")
		meas(1'b1, 30);
		`CHK(d, 2, "train gap")
		`CHK(w, 3, "train second")
		stop(h + 8'h01, 1'b1);
		stop(h, 1'b0);
		// line lags the generator level by one register
		@(posedge clk_i);
		meas(1'b1, 20);
		`CHK(w, 0, "halted")
		poke(3'h4, 3'h5);
		$display("t_train done");
	endtask
	task automatic t_enc;
		dsel = 2'h0;
		req(mk(2'h1, 1'b0, 3'h4, 3'h0, tpg_pkg::EV_IMMEDIATE, 3'h0, 1'b1, 1'b1, 32'h0, 32'h0));
		meas(1'b1, 40);
		`CHK(w, 4, "zero width one count")
		`CHK(d inside {[3:6]}, 1'b1, "zero delay one count")
		$display("t_enc done");
	endtask
	task automatic t_lines;
		dsel = 2'h0;
		for (int t = 1; t <= 2; t++) begin
			req(mk(2'h1, 1'b0, t[2:0], 3'h1, 5'h00, 3'h0, 1'b1, 1'b0, 32'h1, 32'h2));
			poke(t[2:0], 3'h1);
			meas(1'b1, 30);
			`CHK(w, 2, "line stimulus")
			poke(t[2:0], 3'h1);
		end
		$display("t_lines done");
	endtask
	task automatic t_refuse;
		tpg_pkg::tpg_cfg_t c[3];
		logic [4:0] ev[7] = '{5'h08, 5'h09, 5'h0a, 5'h0f, 5'h10, 5'h12, 5'h13};
		c[0] = mk(2'h2, 1'b0, 3'h3, 3'h0, 5'h00, 3'h0, 1'b1, 1'b0, 32'h1, 32'h1);
		c[1] = mk(2'h2, 1'b0, 3'h0, 3'h0, 5'h00, 3'h2, 1'b1, 1'b0, 32'h1, 32'h1);
		c[2] = mk(2'h2, 1'b0, 3'h4, 3'h0, 5'h13, 3'h0, 1'b1, 1'b0, 32'h1, 32'h1);
		@(posedge clk_i) line_scan_i <= 1'b1;
		foreach (c[i]) begin
			req(c[i]);
			`CHK(resp_o.err_param, 1'b1, "refused")
		end
		`CHK(busy_o, 2'h0, "refusal kept state")
		@(posedge clk_i) line_scan_i <= 1'b0;
		foreach (ev[i]) begin
			req(mk(2'h2, 1'b0, 3'h4, 3'h0, ev[i], 3'h1, 1'b1, 1'b0, 32'h1, 32'h1));
			`CHK(resp_o.err_param, 1'b0, "event code")
			stop(resp_o.handle, 1'b0);
		end
		@(posedge clk_i) cam_reserved_i <= 2'h1;
		c[0] = mk(2'h0, 1'b0, 3'h4, 3'h0, 5'h10, 3'h0, 1'b1, 1'b0, 32'h4, 32'h4);
		req(c[0]);
		h = resp_o.handle;
		`CHK(busy_o, 2'h2, "camera share")
		req(c[0]);
		`CHK(resp_o.err_exhaust, 1'b1, "exhausted")
		stop(h, 1'b0);
		@(posedge clk_i) cam_reserved_i <= 2'h0;
		$display("t_refuse done");
	endtask

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// bound well above the few hundred cycles the scenarios need
	initial begin
		repeat (6000) @(posedge clk_i);
		n_errors++;
		$display("MISMATCH %0t timeout", $time);
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_single;
		t_edge;
		t_train;
		t_enc;
		t_lines;
		t_refuse;
		print_verdict;
	end
endmodule
`default_nettype wire

// ---- tb/tpg_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module tpg_checker #(
	parameter int NUM_GEN   = 2,
	parameter int NUM_LINES = 8
) (
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               cfg_valid_i,
	input wire tpg_pkg::tpg_cfg_t  cfg_i,
	input wire logic               line_scan_i,
	input wire logic [NUM_GEN-1:0] cam_reserved_i,
	input wire tpg_pkg::tpg_resp_t resp_o,
	input wire logic [NUM_GEN-1:0] busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	tpg_pkg::tpg_mode_t m_q;
	logic               have_q;
	logic [7:0]         h_q;
	wire                is_cfg = cfg_valid_i && cfg_i.mode != tpg_pkg::MODE_STOP;
	wire                acc_ok = resp_o.ack && !resp_o.err_param && !resp_o.err_exhaust && m_q != tpg_pkg::MODE_STOP;

	// last accepted handle, so freshness is checked across requests
	always_ff @(posedge clk_i) begin
		m_q <= cfg_i.mode;
		if (rst_i) begin
			have_q <= 1'b0;
			h_q    <= tpg_pkg::HANDLE_RST;
		end else if (acc_ok) begin
			have_q <= 1'b1;
			h_q    <= resp_o.handle;
		end
	end

	property p_ack; cfg_valid_i |=> resp_o.ack; endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_hold; !cfg_valid_i |=> !resp_o.ack && $stable(resp_o.handle); endproperty
	a_hold: assert property (p_hold) else $error("answer without request");
	property p_handle; acc_ok |-> resp_o.handle == (have_q ? h_q + 8'h01 : tpg_pkg::HANDLE_RST); endproperty
	a_handle: assert property (p_handle) else $error("handle not fresh");
	property p_stim; is_cfg && !(cfg_i.stim_type inside {3'h0, 3'h1, 3'h2, 3'h4}) |=> resp_o.err_param; endproperty
	a_stim: assert property (p_stim) else $error("bad stimulus type taken");
	property p_dst; is_cfg && !(cfg_i.dst_type inside {3'h0, 3'h1, 3'h3}) |=> resp_o.err_param; endproperty
	a_dst: assert property (p_dst) else $error("bad output type taken");
	property p_vsync;
		is_cfg && cfg_i.stim_type == tpg_pkg::LINE_STATUS && cfg_i.status_ev == tpg_pkg::EV_VSYNC && line_scan_i
			|=> resp_o.err_param;
	endproperty
	a_vsync: assert property (p_vsync) else $error("frame sync taken in line scan");
	property p_exh; is_cfg && &(busy_o | cam_reserved_i) |=> resp_o.err_exhaust || resp_o.err_param; endproperty
	a_exh: assert property (p_exh) else $error("no generator left but taken");
	property p_keep;
		resp_o.ack && (resp_o.err_param || resp_o.err_exhaust) |-> $countones(busy_o) <= $countones($past(busy_o));
	endproperty
	a_keep: assert property (p_keep) else $error("refused request allocated");
	property p_stop;
		resp_o.ack && m_q == tpg_pkg::MODE_STOP && !resp_o.err_handle |-> $countones(busy_o) < $countones($past(busy_o));
	endproperty
	a_stop: assert property (p_stop) else $error("stop freed nothing");
endmodule

bind tpg_top tpg_checker #(.NUM_GEN(NUM_GEN), .NUM_LINES(NUM_LINES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cfg_valid_i(cfg_valid_i), .cfg_i(cfg_i), .line_scan_i(line_scan_i), .cam_reserved_i(cam_reserved_i),
	.resp_o(resp_o), .busy_o(busy_o));
`default_nettype wire

// ---- tb/tpg_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// equipment on the trigger lines: toggles one chosen input line per request
module tpg_line_model (
	input  wire logic            clk_i,
	input  wire logic            fire_i,
	input  wire logic [2:0]      typ_i,
	input  wire logic [2:0]      num_i,
	input  wire logic [7:0]      ext_out_i,
	input  wire logic [7:0]      ext_oe_i,
	input  wire logic [7:0]      sync_out_i,
	input  wire logic [7:0]      sync_oe_i,
	output logic [7:0]           ext_in_o,
	output logic [7:0]           sync_in_o,
	output logic [7:0]           iso_in_o,
	output tpg_pkg::tpg_status_t status_o
);
	logic [7:0] ext_q  = '0;
	logic [7:0] sync_q = '0;
	logic [7:0] iso_q  = '0;
	logic [5:0] st_q   = '0;
	// shared lines read back the block's level wherever it drives
	assign ext_in_o  = (ext_oe_i & ext_out_i) | (~ext_oe_i & ext_q);
	assign sync_in_o = (sync_oe_i & sync_out_i) | (~sync_oe_i & sync_q);
	assign iso_in_o  = iso_q;
	assign status_o  = st_q;
	always_ff @(posedge clk_i) begin
		if (fire_i) begin
			case (typ_i)
				3'h0: ext_q[num_i] <= ~ext_q[num_i];
				3'h1: sync_q[num_i] <= ~sync_q[num_i];
				3'h2: iso_q[num_i] <= ~iso_q[num_i];
				default: st_q[num_i] <= ~st_q[num_i];
			endcase
		end
	end
endmodule
`default_nettype wire
